// File: verilog/dee_defines.svh
`ifndef DEE_DEFINES_SVH
`define DEE_DEFINES_SVH

// ============================================================
// Register locations
`define DEE_SECTOR_DIRECT 8'h00
`define DEE_SECTOR_CTRL 8'h01
`define DEE_OFS_ADDRESS 8'h46
`define DEE_OFS_DATA 8'h47
`define DEE_OFS_CONTROL 8'h40

// ============================================================
// Control fields
`define DEE_BIT_RESERVED 7
`define DEE_BIT_WR_PERMIT 3
`define DEE_BIT_WR_START 2
`define DEE_BIT_RD_PERMIT 1
`define DEE_BIT_RD_START 0
`define DEE_ADDR_MASK 8'h3F

// ============================================================
// Reset values and timing
`define DEE_RST_ADDRESS 8'h00
`define DEE_RST_DATA 8'h00
`define DEE_RST_CONTROL 8'h00
`define DEE_READ_CYCLES 3
`define DEE_WRITE_TICKS 128

`endif

// File: verilog/dee_pkg.sv
package dee_pkg;
  typedef enum logic [1:0] {
    DEE_IDLE = 2'b00,
    DEE_READ = 2'b01,
    DEE_WRITE = 2'b10
  } dee_state_e;
  typedef logic [7:0] dee_byte_t;
endpackage

// File: verilog/dee_mem_if.sv
`timescale 1ns/100ps
interface dee_mem_if #(parameter int ADDR_W = 6);
  logic we;
  logic re;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output re, output addr, output wdata,
    input rdata);
  modport mem (input we, input re, input addr, input wdata,
    output rdata);
endinterface

// File: verilog/dee_array.sv
`timescale 1ns/100ps
module dee_array #(
  parameter int DEPTH = 64,
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Port from the controller
  dee_mem_if.mem port
);
  // ============================================================
  // Storage
  // No reset on the cells: contents must survive a reset
  logic [7:0] cells [DEPTH];

  // Refused at elaboration: a partial array would alias addresses
  if (DEPTH != (1 << ADDR_W)) begin
    $error("DEPTH must equal two to the power ADDR_W");
  end

  always_ff @(posedge CLK) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      port.rdata <= 8'h00;
    end else if (port.re) begin
      port.rdata <= cells[port.addr];
    end
  end
endmodule

// File: verilog/dee_ctrl.sv
`timescale 1ns/100ps
`include "dee_defines.svh"
module dee_ctrl #(
  parameter int DEPTH = 64,
  parameter int ADDR_W = 6,
  parameter int READ_CYCLES = `DEE_READ_CYCLES,
  parameter int WRITE_TICKS = `DEE_WRITE_TICKS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Special function register access
  input wire logic [7:0] SFR_SECTOR,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Write timer clock
  input wire logic LOW_SPEED_SUBCLOCK,
  // Interrupt side
  input wire logic WRITE_DONE_IRQ_ENABLE,
  input wire logic WRITE_DONE_FLAG_CLR,
  output logic WRITE_DONE_REQUEST_FLAG,
  output logic WRITE_DONE_IRQ,
  // Status
  output logic NVM_BUSY
);
  // ============================================================
  // Checks
  if (READ_CYCLES < 3) begin
    $error("READ_CYCLES must be at least 3");
  end
  if (WRITE_TICKS < 1 || WRITE_TICKS > 65535) begin
    $error("WRITE_TICKS out of range");
  end
  if (ADDR_W > 6 || DEPTH != (1 << ADDR_W)) begin
    $error("DEPTH and ADDR_W must agree, at most 64 bytes");
  end

  // ============================================================
  // Decode
  function automatic logic hit(input logic [7:0] sec, input logic [7:0] ofs,
    input logic [7:0] want_sec, input logic [7:0] want_ofs);
    hit = (sec == want_sec) && (ofs == want_ofs);
  endfunction

  logic hit_addr;
  logic hit_data;
  logic hit_ctrl;
  assign hit_addr = hit(SFR_SECTOR, SFR_ADDR, `DEE_SECTOR_DIRECT,
    `DEE_OFS_ADDRESS);
  assign hit_data = hit(SFR_SECTOR, SFR_ADDR, `DEE_SECTOR_DIRECT,
    `DEE_OFS_DATA);
  // Only the indirect sector-one path reaches control
  assign hit_ctrl = hit(SFR_SECTOR, SFR_ADDR, `DEE_SECTOR_CTRL,
    `DEE_OFS_CONTROL);

  // ============================================================
  // State
  dee_mem_if #(.ADDR_W(ADDR_W)) mem ();

  dee_array #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_array (
    .CLK(CLK),
    .NRST(NRST),
    .port(mem.mem)
  );

  dee_pkg::dee_state_e state;
  dee_pkg::dee_byte_t addr_reg;
  dee_pkg::dee_byte_t data_reg;
  logic reserved_top_bit;
  logic write_permit;
  logic write_start;
  logic read_permit;
  logic read_start;
  logic [7:0] read_cnt;
  logic [15:0] tick_cnt;
  logic sub_prev;
  logic sub_tick;
  logic ctrl_wr;
  logic take_write;
  logic take_read;
  logic read_end;
  logic write_end;

  assign ctrl_wr = SFR_WR && hit_ctrl;
  // Permit must already be set before the start write arrives
  assign take_write = ctrl_wr && (state == dee_pkg::DEE_IDLE) &&
    SFR_WDATA[`DEE_BIT_WR_START] && write_permit;
  assign take_read = ctrl_wr && (state == dee_pkg::DEE_IDLE) &&
    !take_write && SFR_WDATA[`DEE_BIT_RD_START] && read_permit;
  assign read_end = (state == dee_pkg::DEE_READ) &&
    (read_cnt == 8'(READ_CYCLES - 1));
  assign sub_tick = LOW_SPEED_SUBCLOCK && !sub_prev;
  assign write_end = (state == dee_pkg::DEE_WRITE) && sub_tick &&
    (tick_cnt == 16'(WRITE_TICKS - 1));

  // ============================================================
  // Sequencer
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= dee_pkg::DEE_IDLE;
    end else begin
      case (state)
        dee_pkg::DEE_IDLE: begin
          if (take_write) begin
            state <= dee_pkg::DEE_WRITE;
          end else if (take_read) begin
            state <= dee_pkg::DEE_READ;
          end
        end
        dee_pkg::DEE_READ: begin
          if (read_end) begin
            state <= dee_pkg::DEE_IDLE;
          end
        end
        dee_pkg::DEE_WRITE: begin
          if (write_end) begin
            state <= dee_pkg::DEE_IDLE;
          end
        end
        default: begin
          state <= dee_pkg::DEE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      read_cnt <= 8'h00;
    end else if (take_read || state != dee_pkg::DEE_READ) begin
      read_cnt <= 8'h00;
    end else begin
      read_cnt <= read_cnt + 8'h01;
    end
  end

  // Subclock is sampled, so its edges cost up to a system cycle of jitter
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sub_prev <= 1'b0;
      tick_cnt <= 16'h0000;
    end else begin
      sub_prev <= LOW_SPEED_SUBCLOCK;
      if (take_write) begin
        tick_cnt <= 16'h0000;
      end else if (state == dee_pkg::DEE_WRITE && sub_tick) begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  // ============================================================
  // Memory port
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mem.we <= 1'b0;
      mem.re <= 1'b0;
      mem.addr <= '0;
      mem.wdata <= 8'h00;
    end else begin
      mem.re <= take_read;
      mem.we <= write_end;
      if (take_read || take_write) begin
        mem.addr <= addr_reg[ADDR_W-1:0];
        mem.wdata <= data_reg;
      end
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      addr_reg <= `DEE_RST_ADDRESS;
    end else if (SFR_WR && hit_addr) begin
      addr_reg <= SFR_WDATA & `DEE_ADDR_MASK;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      data_reg <= `DEE_RST_DATA;
    end else if (read_end) begin
      data_reg <= mem.rdata;
    end else if (SFR_WR && hit_data) begin
      data_reg <= SFR_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      reserved_top_bit <= 1'(`DEE_RST_CONTROL >> `DEE_BIT_RESERVED);
      write_permit <= 1'b0;
      read_permit <= 1'b0;
    end else if (ctrl_wr) begin
      reserved_top_bit <= SFR_WDATA[`DEE_BIT_RESERVED];
      write_permit <= SFR_WDATA[`DEE_BIT_WR_PERMIT];
      read_permit <= SFR_WDATA[`DEE_BIT_RD_PERMIT];
    end
  end

  // Start bits only clear by hardware; software zeros are ignored
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      write_start <= 1'b0;
      read_start <= 1'b0;
    end else begin
      if (take_write) begin
        write_start <= 1'b1;
      end else if (write_end) begin
        write_start <= 1'b0;
      end
      if (take_read) begin
        read_start <= 1'b1;
      end else if (read_end) begin
        read_start <= 1'b0;
      end
    end
  end

  // ============================================================
  // Write-done flag, set beats clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WRITE_DONE_REQUEST_FLAG <= 1'b0;
    end else if (write_end) begin
      WRITE_DONE_REQUEST_FLAG <= 1'b1;
    end else if (WRITE_DONE_FLAG_CLR) begin
      WRITE_DONE_REQUEST_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WRITE_DONE_IRQ <= 1'b0;
    end else begin
      WRITE_DONE_IRQ <= (WRITE_DONE_REQUEST_FLAG || write_end) &&
        !(WRITE_DONE_FLAG_CLR && !write_end) &&
        WRITE_DONE_IRQ_ENABLE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      NVM_BUSY <= 1'b0;
    end else begin
      NVM_BUSY <= (take_read || take_write ||
        state != dee_pkg::DEE_IDLE) && !read_end && !write_end;
    end
  end

  // ============================================================
  // Read back
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (hit_addr) begin
      next_rdata = addr_reg & `DEE_ADDR_MASK;
    end else if (hit_data) begin
      next_rdata = data_reg;
    end else if (hit_ctrl) begin
      next_rdata = 8'h00;
      next_rdata[`DEE_BIT_RESERVED] = reserved_top_bit;
      next_rdata[`DEE_BIT_WR_PERMIT] = write_permit;
      next_rdata[`DEE_BIT_WR_START] = write_start;
      next_rdata[`DEE_BIT_RD_PERMIT] = read_permit;
      next_rdata[`DEE_BIT_RD_START] = read_start;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      SFR_RDATA <= next_rdata;
    end else begin
      SFR_RDATA <= 8'h00;
    end
  end
endmodule

// File: tb/dee_ctrl_properties.sv
`timescale 1ns/100ps
// ========
// Port checker
module dee_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Register access
  input wire logic [7:0] SFR_SECTOR,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Interrupt and status
  input wire logic WRITE_DONE_IRQ_ENABLE,
  input wire logic WRITE_DONE_FLAG_CLR,
  input wire logic WRITE_DONE_REQUEST_FLAG,
  input wire logic WRITE_DONE_IRQ,
  input wire logic NVM_BUSY
);
  logic ctl, rd_adr, rd_ctl, rd_hid, go, rd_go;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  assign ctl = SFR_SECTOR == 8'h01 && SFR_ADDR == 8'h40;
  assign rd_adr = SFR_RD && SFR_SECTOR == 8'h00 && SFR_ADDR == 8'h46;
  assign rd_ctl = SFR_RD && ctl;
  assign rd_hid = SFR_RD && SFR_SECTOR == 8'h00 && SFR_ADDR == 8'h40;
  assign go = SFR_WR && ctl && (SFR_WDATA[2] || SFR_WDATA[0]);
  assign rd_go = go && SFR_WDATA[2:0] == 3'h3;
  rd_idle_a: assert property (!$past(SFR_RD) |->
    SFR_RDATA == 8'h00) else $error("read data not idle zero");
  addr_top_a: assert property ($past(rd_adr) |->
    SFR_RDATA[7:6] == 2'b00) else $error("address top bits set");
  ctl_gap_a: assert property ($past(rd_ctl) |->
    SFR_RDATA[6:4] == 3'h0) else $error("control gap bits set");
  ctl_hidden_a: assert property ($past(rd_hid) |->
    SFR_RDATA == 8'h00) else $error("control seen in sector zero");
  busy_cause_a: assert property ($rose(NVM_BUSY) |->
    $past(go)) else $error("busy without a start");
  read_len_a: assert property ($rose(NVM_BUSY) && $past(rd_go) |->
    ##[2:4] !NVM_BUSY) else $error("read too long");
  flag_hold_a: assert property (
    WRITE_DONE_REQUEST_FLAG && !WRITE_DONE_FLAG_CLR
    |=> WRITE_DONE_REQUEST_FLAG) else $error("flag dropped");
  flag_clr_a: assert property (WRITE_DONE_FLAG_CLR && !NVM_BUSY
    |=> !WRITE_DONE_REQUEST_FLAG) else $error("flag not cleared");
  flag_end_a: assert property ($rose(WRITE_DONE_REQUEST_FLAG) |->
    $past(NVM_BUSY) ##1 !NVM_BUSY) else $error("flag off write end");
  irq_out_a: assert property (1'b1 |-> WRITE_DONE_IRQ ==
    (WRITE_DONE_REQUEST_FLAG && $past(WRITE_DONE_IRQ_ENABLE)))
    else $error("irq mismatch");
endmodule
bind dee_ctrl dee_props chk (.CLK, .NRST, .SFR_SECTOR, .SFR_ADDR,
  .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA, .WRITE_DONE_IRQ_ENABLE,
  .WRITE_DONE_FLAG_CLR, .WRITE_DONE_REQUEST_FLAG, .WRITE_DONE_IRQ,
  .NVM_BUSY);

// File: tb/dee_cpu.sv
`timescale 1ns/100ps
// ========
// Core side of the register bus
module dee_cpu (
  // Clock
  input wire logic CLK,
  // Register access
  output logic [7:0] SECTOR,
  output logic [7:0] ADDR,
  output logic WR,
  output logic RD,
  output logic [7:0] WDATA,
  input wire logic [7:0] RDATA
);
  initial begin
    SECTOR = 8'h00;
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
  end
  // Held across exactly one rising edge
  task automatic put(input logic [7:0] s, a, d, input logic w);
    @(negedge CLK);
    SECTOR = s;
    ADDR = a;
    WDATA = d;
    WR = w;
    RD = !w;
    @(posedge CLK);
  endtask
  // Stale lines flip so an old value never passes
  task automatic rel();
    @(negedge CLK);
    WR = 1'b0;
    RD = 1'b0;
    ADDR = ~ADDR;
    WDATA = ~WDATA;
  endtask
  task automatic set(input logic [7:0] s, a, d);
    put(s, a, d, 1'b1);
    rel();
  endtask
  task automatic get(input logic [7:0] s, a, output logic [7:0] d);
    put(s, a, 8'h00, 1'b0);
    rel();
    d = RDATA;
  endtask
  // Permit, then start on the very next cycle; no interrupt between
  task automatic go(input logic [7:0] p);
    put(8'h01, 8'h40, p, 1'b1);
    put(8'h01, 8'h40, p | (p >> 1), 1'b1);
    rel();
  endtask
endmodule

// File: tb/dee_ctrl_tb.sv
`timescale 1ns/100ps
// ========
// Bench
module dee_ctrl_tb;
  logic clk = 1'b0;
  logic nrst, sub, en, clr, wr, rd, flag, irq, busy;
  logic [7:0] sec, adr, wd, rdat, v, a;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h74F2CD63;
  logic [7:0] mem [int];
  logic [7:0] q [$];
  logic [7:0] t_sec [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h02};
  logic [7:0] t_ofs [5] = '{8'h46, 8'h47, 8'h40, 8'h40, 8'h40};
  // Reserved control bit is kept at zero by software
  logic [7:0] t_wr [5] = '{8'hFF, 8'hA5, 8'h70, 8'h0C, 8'h0C};
  logic [7:0] t_exp [5] = '{8'h3F, 8'hA5, 8'h00, 8'h00, 8'h00};
  always #2 clk = ~clk;
  // Subclock moves on falling edges, clear of the sampling edge
  always #16 sub = ~sub;
  dee_cpu cpu (.CLK(clk), .SECTOR(sec), .ADDR(adr), .WR(wr), .RD(rd),
    .WDATA(wd), .RDATA(rdat));
  // Short write timer keeps the run brief
  dee_ctrl #(.WRITE_TICKS(4)) uut (.CLK(clk), .NRST(nrst),
    .SFR_SECTOR(sec), .SFR_ADDR(adr), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_WDATA(wd), .SFR_RDATA(rdat), .LOW_SPEED_SUBCLOCK(sub),
    .WRITE_DONE_IRQ_ENABLE(en), .WRITE_DONE_FLAG_CLR(clr),
    .WRITE_DONE_REQUEST_FLAG(flag), .WRITE_DONE_IRQ(irq),
    .NVM_BUSY(busy));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic poll(input int b);
    int n = 0;
    v = 8'hFF;
    while (v[b] === 1'b1 && n < 300) begin
      cpu.get(8'h01, 8'h40, v);
      n++;
    end
  endtask
  task automatic wop(input logic [7:0] a, d);
    cpu.set(8'h00, 8'h46, a);
    cpu.set(8'h00, 8'h47, d);
    en = ~en;
    cpu.go(8'h08);
    check("write busy", {7'h0, busy}, 8'h01);
    poll(2);
    check("control", v, 8'h08);
    mem[a & 8'h3F] = d;
    repeat (2) @(negedge clk);
    check("flag", {7'h0, flag}, 8'h01);
    check("irq", {7'h0, irq}, {7'h0, en});
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    check("flag clear", {7'h0, flag}, 8'h00);
    check("irq clear", {7'h0, irq}, 8'h00);
  endtask
  task automatic rop(input logic [7:0] a);
    cpu.set(8'h00, 8'h46, a);
    cpu.go(8'h02);
    check("read busy", {7'h0, busy}, 8'h01);
    poll(0);
    check("control", v, 8'h02);
    cpu.get(8'h00, 8'h47, v);
    check("read data", v, mem[a & 8'h3F]);
    cpu.set(8'h00, 8'h46, ~a);
    cpu.get(8'h00, 8'h47, v);
    check("held data", v, mem[a & 8'h3F]);
  endtask
  initial begin
    nrst = 1'b0;
    sub = 1'b0;
    en = 1'b0;
    clr = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    foreach (t_sec[i]) begin
      cpu.get(t_sec[i], t_ofs[i], v);
      check("reset value", v, 8'h00);
      cpu.set(t_sec[i], t_ofs[i], t_wr[i]);
      cpu.get(t_sec[i], t_ofs[i], v);
      check("readback", v, t_exp[i]);
    end
    cpu.set(8'h01, 8'h40, 8'h00);
    for (int i = 0; i < 2; i++) begin
      cpu.set(8'h01, 8'h40, i ? 8'h01 : 8'h04);
      check("busy", {7'h0, busy}, 8'h00);
      cpu.get(8'h01, 8'h40, v);
      check("refused", v, 8'h00);
    end
    // Top location plus random bytes and addresses
    q.push_back(8'h3F);
    repeat (5) begin
      a = 8'(rnd());
      q.push_back(a);
    end
    foreach (q[i]) wop(q[i], 8'(rnd()));
    foreach (q[i]) rop(q[i]);
    end_sim();
  end
  initial begin
    #40000;
    errors++;
    end_sim();
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
endmodule
